// ---- tb/cdsb_host_model.sv ----
// Purpose: Host processor on the paged register port
// Assumes: Strobes change at the falling edge of mclk
// Notes: Idle write data shows the inverse of the last word, never a stale copy
`timescale 1ns/1ns
`include "cdsb_consts.svh"
module cdsb_host_model #(
	parameter int SETTLE_CYCLES = 8
) (
	// Clock
	input wire logic mclk,
	// Register port
	output logic [4:0] bus_addr,
	output cdsb_pkg::cdsb_word_type bus_wdata,
	output logic bus_wr,
	output logic bus_rd,
	input wire cdsb_pkg::cdsb_word_type bus_rdata
);
	import cdsb_pkg::*;
	// ****************
	// Bus cycles
	// ****************
	initial begin
		bus_addr = 5'h00;
		bus_wdata = 16'h0000;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
	end
	task automatic put(input logic [4:0] a, input cdsb_word_type d);
		@(negedge mclk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge mclk);
		bus_wr = 1'b0;
		bus_wdata = ~d;
	endtask
	// Data sampled a full cycle late, safe since read data holds
	task automatic get(input logic [4:0] a, output cdsb_word_type d);
		@(negedge mclk);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge mclk);
		bus_rd = 1'b0;
		@(negedge mclk);
		d = bus_rdata;
	endtask
	// Scaled wait before wrap angle readback
	task automatic settle();
		repeat (SETTLE_CYCLES) @(negedge mclk);
	endtask
	task automatic abort_stim();
		put(`CDSB_CTRL_OFS, 16'h0000);
	endtask
endmodule

// ---- tb/channel_diagnostic_status_bank_test.sv ----
// Purpose: Self-checking bench of the diagnostic status bank
// Assumes: Scaled loss and stimulus step counts
// Notes: Inputs change at the falling edge
`timescale 1ns/1ns
`include "cdsb_consts.svh"
module channel_diagnostic_status_bank_test;
	import cdsb_pkg::*;
	localparam int SIGC = 20;
	localparam int STEPC = 10;
	logic mclk, sys_rst, bus_wr, bus_rd, input_isolate, stim_enable;
	logic [4:0] bus_addr;
	cdsb_word_type bus_wdata, bus_rdata, stim_angle, rv, wv;
	logic [`CDSB_NCH-1:0][15:0] meas_freq, meas_sig_volt, meas_ref_volt, meas_pos, pos_out;
	logic [`CDSB_NCH-1:0] online_acc_err, bw_auto, comm_mode;
	logic [`CDSB_NCH-1:0][2:0] enc_res;
	int fails, comparisons, cycles, n;
	int sthr[`CDSB_NCH];
	int rthr[`CDSB_NCH];
	cdsb_status_bank #(.SIG_LOSS_CYCLES(SIGC), .OFF_STEP_CYCLES(STEPC)) dut (.mclk(mclk), .sys_rst(sys_rst),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.meas_freq(meas_freq), .meas_sig_volt(meas_sig_volt), .meas_ref_volt(meas_ref_volt),
		.meas_pos(meas_pos), .online_acc_err(online_acc_err), .pos_out(pos_out), .input_isolate(input_isolate),
		.stim_enable(stim_enable), .stim_angle(stim_angle), .bw_auto(bw_auto), .enc_res(enc_res),
		.comm_mode(comm_mode));
	cdsb_host_model host (.mclk(mclk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata));
	// ****************
	// Clock, limit, report
	// ****************
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input cdsb_word_type seen, input cdsb_word_type exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic page(input logic [3:0] p);
		host.put(`CDSB_PAGE_OFS, 16'(p));
	endtask
	task automatic rchk(input logic [4:0] a, input cdsb_word_type exp);
		host.get(a, rv);
		chk(rv, exp);
	endtask
	// ****************
	// Scenarios
	// ****************
	initial begin
		sys_rst = 1'b1;
		meas_freq = '0;
		meas_pos = '0;
		online_acc_err = '0;
		meas_sig_volt = {`CDSB_NCH{16'h0400}};
		meas_ref_volt = {`CDSB_NCH{16'h0400}};
		void'($urandom(32'hec9455d9));
		repeat (8) @(negedge mclk);
		sys_rst = 1'b0;
		page(`CDSB_PG_RES);
		for (int i = 0; i < `CDSB_NCH; i++) begin
			rchk(`CDSB_RES_BASE + 5'(2 * i), `CDSB_RES_RST);
			chk(16'(enc_res[i]), `CDSB_RES_RST & 16'h0007);
			wv = {i[0], 12'h000, 3'($urandom_range(7))};
			host.put(`CDSB_RES_BASE + 5'(2 * i), wv);
			repeat (2) @(negedge mclk);
			chk(16'(enc_res[i]), wv & 16'h0007);
			chk(16'(comm_mode[i]), 16'(wv[15]));
		end
		// Thresholds land at random values; measurements sit exactly on them
		page(`CDSB_PG_THR);
		for (int i = 0; i < `CDSB_NCH; i++) begin
			rchk(5'(2 * i), `CDSB_SIG_THR_RST);
			rchk(`CDSB_REF_BASE + 5'(2 * i), `CDSB_REF_THR_RST);
			sthr[i] = $urandom_range(16'h7fff, 16'h0010);
			rthr[i] = $urandom_range(16'h7fff, 16'h0010);
			host.put(5'(2 * i), 16'(sthr[i]));
			host.put(`CDSB_REF_BASE + 5'(2 * i), 16'(rthr[i]));
			rchk(5'(2 * i), 16'(sthr[i]));
			rchk(`CDSB_REF_BASE + 5'(2 * i), 16'(rthr[i]));
			meas_sig_volt[i] = 16'(sthr[i]);
			meas_ref_volt[i] = 16'(rthr[i]);
			meas_freq[i] = 16'($urandom);
		end
		page(`CDSB_PG_FREQ);
		for (int i = 0; i < `CDSB_NCH; i++) begin
			rchk(5'(4 * i), meas_freq[i]);
			rchk(5'(4 * i + 2), 16'h0000);
		end
		page(`CDSB_PG_VOLT);
		for (int i = 0; i < `CDSB_NCH; i++) begin
			rchk(5'(2 * i), meas_sig_volt[i]);
			rchk(`CDSB_REF_BASE + 5'(2 * i), meas_ref_volt[i]);
		end
		page(`CDSB_PG_BW);
		wv = 16'($urandom);
		host.put(`CDSB_BW_SEL_OFS, wv);
		rchk(`CDSB_BW_SEL_OFS, wv & 16'h003f);
		chk(16'(bw_auto), wv & 16'h003f);
		// Channel six inactive and left with its reference dead
		page(`CDSB_PG_TEST);
		host.put(`CDSB_ACTIVE_OFS, 16'h001f);
		meas_ref_volt[5] = 16'h0000;
		meas_ref_volt[0] = 16'(rthr[0] - 1);
		@(negedge mclk);
		meas_ref_volt[0] = 16'(rthr[0]);
		rchk(`CDSB_REF_STAT_OFS, 16'h0001);
		rchk(`CDSB_SUM_STAT_OFS, 16'h0002);
		rchk(`CDSB_REF_STAT_OFS, 16'h0000);
		rchk(`CDSB_SUM_STAT_OFS, 16'h0000);
		meas_ref_volt[1] = 16'(rthr[1] - 1);
		rchk(`CDSB_REF_STAT_OFS, 16'h0002);
		rchk(`CDSB_REF_STAT_OFS, 16'h0002);
		meas_ref_volt[1] = 16'(rthr[1]);
		rchk(`CDSB_REF_STAT_OFS, 16'h0002);
		rchk(`CDSB_REF_STAT_OFS, 16'h0000);
		rchk(`CDSB_SUM_STAT_OFS, 16'h0002);
		for (int k = 0; k < 2; k++) begin
			meas_sig_volt[1] = 16'(sthr[1] - 1);
			repeat (SIGC - 5 + 10 * k) @(negedge mclk);
			meas_sig_volt[1] = 16'(sthr[1]);
			rchk(`CDSB_SIG_STAT_OFS, 16'(2 * k));
		end
		rchk(`CDSB_SUM_STAT_OFS, 16'h0001);
		wv = 16'($urandom);
		host.put(`CDSB_ANGLE_OFS, wv);
		host.put(`CDSB_CTRL_OFS, 16'h0001);
		meas_ref_volt[2] = 16'h0000;
		host.settle();
		for (int i = 0; i < `CDSB_NCH; i++)
			chk(pos_out[i], wv);
		chk(16'(input_isolate), 16'h0001);
		rchk(`CDSB_REF_STAT_OFS, 16'h0000);
		meas_ref_volt[2] = 16'(rthr[2]);
		host.put(`CDSB_CTRL_OFS, 16'h0000);
		meas_pos = {`CDSB_NCH{16'($urandom)}};
		repeat (2) @(negedge mclk);
		chk(pos_out[3], meas_pos[3]);
		// Same error burst with the check off, then on
		for (int e = 0; e < 2; e++) begin
			host.put(`CDSB_CTRL_OFS, 16'(4 * e));
			online_acc_err = 6'h24;
			@(negedge mclk);
			online_acc_err = 6'h00;
			rchk(`CDSB_ACC_STAT_OFS, 16'(4 * e));
		end
		rchk(`CDSB_SUM_STAT_OFS, 16'h0004);
		rchk(`CDSB_ACC_STAT_OFS, 16'h0000);
		meas_pos = '0;
		host.put(`CDSB_CTRL_OFS, 16'h0008);
		@(negedge mclk);
		chk(16'(stim_enable & input_isolate), 16'h0001);
		n = 0;
		while (stim_enable === 1'b1 && n < 2000) begin
			if (n % STEPC == 0)
				chk(stim_angle, 16'((n + 1) / STEPC * `CDSB_ANGLE_STEP));
			@(negedge mclk);
			n++;
		end
		chk(16'(n > 72 * STEPC - 8 && n < 72 * STEPC + 8), 16'h0001);
		rchk(`CDSB_CTRL_OFS, 16'h0000);
		rchk(`CDSB_ACC_STAT_OFS, 16'h001f);
		host.put(`CDSB_CTRL_OFS, 16'h0008);
		repeat (30) @(negedge mclk);
		host.abort_stim();
		@(negedge mclk);
		chk(16'(stim_enable), 16'h0000);
		rchk(`CDSB_CTRL_OFS, 16'h0000);
		// Mid-run reset brings back the resolution, signal threshold and bandwidth select defaults
		sys_rst = 1'b1;
		repeat (2) @(negedge mclk);
		chk(16'(enc_res[0]), `CDSB_RES_RST & 16'h0007);
		sys_rst = 1'b0;
		page(`CDSB_PG_THR);
		rchk(5'h00, `CDSB_SIG_THR_RST);
		page(`CDSB_PG_BW);
		rchk(`CDSB_BW_SEL_OFS, 16'h0000);
		stop_test();
	end
endmodule

// ---- verilog/cdsb_consts.svh ----
// Purpose: Offsets, fields, reset values and timing counts of the diagnostic status bank
// Assumes: 16-bit paged register window, page select at the top word
// Notes: Times in their own units; cycle counts derived from the clock rate
`ifndef CDSB_CONSTS_SVH
`define CDSB_CONSTS_SVH
// ****************************************
// Geometry and pages
// ****************************************
`define CDSB_NCH 6
`define CDSB_PAGE_OFS 5'h1e
`define CDSB_PG_TEST 4'h2
`define CDSB_PG_RES 4'h3
`define CDSB_PG_BW 4'h7
`define CDSB_PG_FREQ 4'h9
`define CDSB_PG_VOLT 4'ha
`define CDSB_PG_THR 4'hb
// ****************************************
// Offsets within a page
// ****************************************
`define CDSB_CTRL_OFS 5'h00
`define CDSB_ANGLE_OFS 5'h02
`define CDSB_ACTIVE_OFS 5'h04
`define CDSB_ACC_STAT_OFS 5'h10
`define CDSB_REF_STAT_OFS 5'h12
`define CDSB_SIG_STAT_OFS 5'h14
`define CDSB_SUM_STAT_OFS 5'h16
`define CDSB_RES_BASE 5'h10
`define CDSB_BW_SEL_OFS 5'h0c
`define CDSB_FREQ_BASE 5'h00
`define CDSB_SIG_BASE 5'h00
`define CDSB_REF_BASE 5'h0c
// ****************************************
// Fields and reset values
// ****************************************
`define CDSB_WRAP_BIT 0
`define CDSB_ONLINE_BIT 2
`define CDSB_OFFLINE_BIT 3
`define CDSB_SUM_SIG_BIT 0
`define CDSB_SUM_REF_BIT 1
`define CDSB_SUM_ACC_BIT 2
`define CDSB_ENC_MODE_BIT 15
`define CDSB_RES_RST 16'h0004
`define CDSB_REF_THR_RST 16'h00c8
`define CDSB_SIG_THR_RST 16'h0190
`define CDSB_ANGLE_STEP 16'h038e
`define CDSB_ACC_TOL 16'h0083
// ****************************************
// Timing
// ****************************************
`define CDSB_CLK_HZ 50000000
`define CDSB_SIG_LOSS_MS 2000
`define CDSB_OFF_TEST_MS 45000
`define CDSB_OFF_ANGLES 72
`define CDSB_SIG_LOSS_CYC (`CDSB_SIG_LOSS_MS * (`CDSB_CLK_HZ / 1000))
`define CDSB_OFF_STEP_CYC ((`CDSB_OFF_TEST_MS / `CDSB_OFF_ANGLES) * (`CDSB_CLK_HZ / 1000))
`endif

// ---- verilog/cdsb_pkg.sv ----
// Purpose: Types shared by the diagnostic status bank
// Assumes: Nothing beyond the constants header
// Notes: Constants live in the header, types here
package cdsb_pkg;
	typedef logic [15:0] cdsb_word_type;
	typedef enum {OFF_IDLE, OFF_RUN} cdsb_off_state_type;
endpackage

// ---- verilog/cdsb_status_bank.sv ----
// Purpose: Measurement readback, loss thresholds, self tests and latched status for six channels
// Assumes: Host strobes and measurement inputs are synchronous to mclk
// Notes: Paged 16-bit register window; status reads clear and reload live state
`timescale 1ns/1ns
`include "cdsb_consts.svh"

module cdsb_status_bank #(
	parameter int unsigned SIG_LOSS_CYCLES = `CDSB_SIG_LOSS_CYC,
	parameter int unsigned OFF_STEP_CYCLES = `CDSB_OFF_STEP_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Host register port
	input wire logic [4:0] bus_addr,
	input wire cdsb_pkg::cdsb_word_type bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output cdsb_pkg::cdsb_word_type bus_rdata,
	// Measurement engine
	input wire logic [`CDSB_NCH-1:0][15:0] meas_freq,
	input wire logic [`CDSB_NCH-1:0][15:0] meas_sig_volt,
	input wire logic [`CDSB_NCH-1:0][15:0] meas_ref_volt,
	input wire logic [`CDSB_NCH-1:0][15:0] meas_pos,
	input wire logic [`CDSB_NCH-1:0] online_acc_err,
	// Channel control
	output logic [`CDSB_NCH-1:0][15:0] pos_out,
	output logic input_isolate,
	output logic stim_enable,
	output cdsb_pkg::cdsb_word_type stim_angle,
	output logic [`CDSB_NCH-1:0] bw_auto,
	output logic [`CDSB_NCH-1:0][2:0] enc_res,
	output logic [`CDSB_NCH-1:0] comm_mode
);
	import cdsb_pkg::*;

	localparam int NCH = `CDSB_NCH;
	localparam int SLW = $clog2(SIG_LOSS_CYCLES + 1);
	localparam int OSW = $clog2(OFF_STEP_CYCLES + 1);

	// ****************************************
	// State
	// ****************************************
	logic [3:0] page, next_page;
	logic [3:0] ctrl, next_ctrl;
	logic [NCH-1:0] active, next_active;
	logic [NCH-1:0] bw_sel, next_bw_sel;
	logic [15:0] test_angle, next_test_angle;
	logic [15:0] res [NCH];
	logic [15:0] next_res [NCH];
	logic [15:0] sig_thr [NCH];
	logic [15:0] next_sig_thr [NCH];
	logic [15:0] ref_thr [NCH];
	logic [15:0] next_ref_thr [NCH];
	logic [NCH-1:0] acc_stat, next_acc_stat;
	logic [NCH-1:0] ref_stat, next_ref_stat;
	logic [NCH-1:0] sig_stat, next_sig_stat;
	logic [2:0] sum_stat, next_sum_stat;
	logic [SLW-1:0] sig_cnt [NCH];
	logic [SLW-1:0] next_sig_cnt [NCH];
	cdsb_off_state_type off_state, next_off_state;
	logic [6:0] off_step, next_off_step;
	logic [OSW-1:0] off_timer, next_off_timer;
	logic [15:0] next_stim_angle;
	logic [NCH-1:0][15:0] next_pos_out;
	logic [15:0] rd_val;

	// ****************************************
	// Strobes and events
	// ****************************************
	logic page_hit, wr_test, rd_test, wr_ctrl, off_start, off_abort, off_done, mon_on;
	logic rd_acc, rd_ref, rd_sig, rd_sum;
	logic [NCH-1:0] off_fail, acc_evt, ref_evt, sig_evt, sig_low;

	assign page_hit = (bus_addr == `CDSB_PAGE_OFS);
	assign wr_test = bus_wr && !page_hit && (page == `CDSB_PG_TEST);
	assign rd_test = bus_rd && !page_hit && (page == `CDSB_PG_TEST);
	assign wr_ctrl = wr_test && (bus_addr == `CDSB_CTRL_OFS);
	assign off_start = wr_ctrl && bus_wdata[`CDSB_OFFLINE_BIT] && !ctrl[`CDSB_OFFLINE_BIT];
	assign off_abort = wr_ctrl && !bus_wdata[`CDSB_OFFLINE_BIT];
	assign rd_acc = rd_test && (bus_addr == `CDSB_ACC_STAT_OFS);
	assign rd_ref = rd_test && (bus_addr == `CDSB_REF_STAT_OFS);
	assign rd_sig = rd_test && (bus_addr == `CDSB_SIG_STAT_OFS);
	assign rd_sum = rd_test && (bus_addr == `CDSB_SUM_STAT_OFS);
	// Monitoring would see the loopback or stimulus, not the field inputs
	assign mon_on = !ctrl[`CDSB_WRAP_BIT] && !ctrl[`CDSB_OFFLINE_BIT];

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			sig_low[i] = meas_sig_volt[i] < sig_thr[i];
			ref_evt[i] = mon_on && active[i] && (meas_ref_volt[i] < ref_thr[i]);
			sig_evt[i] = mon_on && active[i] && sig_low[i] && (sig_cnt[i] == SLW'(SIG_LOSS_CYCLES - 1));
			acc_evt[i] = active[i] && ((ctrl[`CDSB_ONLINE_BIT] && online_acc_err[i]) || off_fail[i]);
		end
	end

	// ****************************************
	// Signal loss persistence counters
	// ****************************************
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			next_sig_cnt[i] = '0;
			if (mon_on && active[i] && sig_low[i]) begin
				next_sig_cnt[i] = sig_evt[i] ? sig_cnt[i] : sig_cnt[i] + SLW'(1);
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NCH; i++) begin
				sig_cnt[i] <= '0;
			end
		end else begin
			sig_cnt <= next_sig_cnt;
		end
	end

	// ****************************************
	// Stimulus test sequencer
	// ****************************************
	always_comb begin
		logic [15:0] diff;
		diff = '0;
		next_off_state = off_state;
		next_off_step = off_step;
		next_off_timer = off_timer;
		next_stim_angle = stim_angle;
		off_fail = '0;
		off_done = 1'b0;
		case (off_state)
			OFF_IDLE: begin
				if (off_start) begin
					next_off_state = OFF_RUN;
					next_off_step = '0;
					next_off_timer = '0;
					next_stim_angle = '0;
				end
			end
			OFF_RUN: begin
				if (off_abort) begin
					next_off_state = OFF_IDLE;
				end else if (off_timer == OSW'(OFF_STEP_CYCLES - 1)) begin
					next_off_timer = '0;
					// Compare only once the converter has had a full step to settle
					for (int i = 0; i < NCH; i++) begin
						diff = meas_pos[i] - stim_angle;
						if (diff[15]) begin
							diff = 16'h0000 - diff;
						end
						off_fail[i] = diff > `CDSB_ACC_TOL;
					end
					if (off_step == 7'(`CDSB_OFF_ANGLES - 1)) begin
						off_done = 1'b1;
						next_off_state = OFF_IDLE;
					end else begin
						next_off_step = off_step + 7'h01;
						next_stim_angle = stim_angle + `CDSB_ANGLE_STEP;
					end
				end else begin
					next_off_timer = off_timer + OSW'(1);
				end
			end
			default: begin
				next_off_state = OFF_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			off_state <= OFF_IDLE;
			off_step <= '0;
			off_timer <= '0;
			stim_angle <= '0;
		end else begin
			off_state <= next_off_state;
			off_step <= next_off_step;
			off_timer <= next_off_timer;
			stim_angle <= next_stim_angle;
		end
	end

	// ****************************************
	// Host-written configuration
	// ****************************************
	always_comb begin
		next_page = page;
		next_ctrl = ctrl;
		next_active = active;
		next_bw_sel = bw_sel;
		next_test_angle = test_angle;
		next_res = res;
		next_sig_thr = sig_thr;
		next_ref_thr = ref_thr;
		if (off_done) begin
			next_ctrl[`CDSB_OFFLINE_BIT] = 1'b0;
		end
		if (bus_wr && page_hit) begin
			next_page = bus_wdata[3:0];
		end else if (bus_wr) begin
			case (page)
				`CDSB_PG_TEST: begin
					case (bus_addr)
						`CDSB_CTRL_OFS: next_ctrl = {bus_wdata[3], bus_wdata[2], 1'b0, bus_wdata[0]};
						`CDSB_ANGLE_OFS: next_test_angle = bus_wdata;
						`CDSB_ACTIVE_OFS: next_active = bus_wdata[NCH-1:0];
						default: ;
					endcase
				end
				`CDSB_PG_RES: begin
					for (int i = 0; i < NCH; i++) begin
						if (bus_addr == 5'(`CDSB_RES_BASE + 2 * i)) begin
							next_res[i] = bus_wdata;
						end
					end
				end
				`CDSB_PG_BW: begin
					if (bus_addr == `CDSB_BW_SEL_OFS) begin
						next_bw_sel = bus_wdata[NCH-1:0];
					end
				end
				`CDSB_PG_THR: begin
					for (int i = 0; i < NCH; i++) begin
						if (bus_addr == 5'(`CDSB_SIG_BASE + 2 * i)) begin
							next_sig_thr[i] = bus_wdata;
						end
						if (bus_addr == 5'(`CDSB_REF_BASE + 2 * i)) begin
							next_ref_thr[i] = bus_wdata;
						end
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			page <= '0;
			ctrl <= '0;
			active <= '0;
			bw_sel <= '0;
			test_angle <= '0;
			for (int i = 0; i < NCH; i++) begin
				res[i] <= `CDSB_RES_RST;
				sig_thr[i] <= `CDSB_SIG_THR_RST;
				ref_thr[i] <= `CDSB_REF_THR_RST;
			end
		end else begin
			page <= next_page;
			ctrl <= next_ctrl;
			active <= next_active;
			bw_sel <= next_bw_sel;
			test_angle <= next_test_angle;
			res <= next_res;
			sig_thr <= next_sig_thr;
			ref_thr <= next_ref_thr;
		end
	end

	// ****************************************
	// Latched status
	// ****************************************
	// A read reloads the live state, so a fault present in that cycle survives
	always_comb begin
		next_acc_stat = (rd_acc ? acc_evt : (acc_stat | acc_evt)) & next_active;
		next_ref_stat = (rd_ref ? ref_evt : (ref_stat | ref_evt)) & next_active;
		next_sig_stat = (rd_sig ? sig_evt : (sig_stat | sig_evt)) & next_active;
		next_sum_stat = rd_sum ? 3'h0 : sum_stat;
		next_sum_stat[`CDSB_SUM_SIG_BIT] = next_sum_stat[`CDSB_SUM_SIG_BIT] | (|sig_evt);
		next_sum_stat[`CDSB_SUM_REF_BIT] = next_sum_stat[`CDSB_SUM_REF_BIT] | (|ref_evt);
		next_sum_stat[`CDSB_SUM_ACC_BIT] = next_sum_stat[`CDSB_SUM_ACC_BIT] | (|acc_evt);
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_stat <= '0;
			ref_stat <= '0;
			sig_stat <= '0;
			sum_stat <= '0;
		end else begin
			acc_stat <= next_acc_stat;
			ref_stat <= next_ref_stat;
			sig_stat <= next_sig_stat;
			sum_stat <= next_sum_stat;
		end
	end

	// ****************************************
	// Read mux and channel outputs
	// ****************************************
	always_comb begin
		rd_val = 16'h0000;
		if (page_hit) begin
			rd_val = {12'h000, page};
		end else begin
			case (page)
				`CDSB_PG_TEST: begin
					case (bus_addr)
						`CDSB_CTRL_OFS: rd_val = {12'h000, ctrl};
						`CDSB_ANGLE_OFS: rd_val = test_angle;
						`CDSB_ACTIVE_OFS: rd_val = {10'h000, active};
						`CDSB_ACC_STAT_OFS: rd_val = {10'h000, acc_stat & active};
						`CDSB_REF_STAT_OFS: rd_val = {10'h000, ref_stat & active};
						`CDSB_SIG_STAT_OFS: rd_val = {10'h000, sig_stat & active};
						`CDSB_SUM_STAT_OFS: rd_val = {13'h0000, sum_stat};
						default: ;
					endcase
				end
				`CDSB_PG_RES: begin
					for (int i = 0; i < NCH; i++) begin
						if (bus_addr == 5'(`CDSB_RES_BASE + 2 * i)) begin
							rd_val = res[i];
						end
					end
				end
				`CDSB_PG_BW: begin
					if (bus_addr == `CDSB_BW_SEL_OFS) begin
						rd_val = {10'h000, bw_sel};
					end
				end
				`CDSB_PG_FREQ: begin
					// High words read zero; the count fits in the low word
					for (int i = 0; i < NCH; i++) begin
						if (bus_addr == 5'(`CDSB_FREQ_BASE + 4 * i)) begin
							rd_val = meas_freq[i];
						end
					end
				end
				`CDSB_PG_VOLT: begin
					for (int i = 0; i < NCH; i++) begin
						if (bus_addr == 5'(`CDSB_SIG_BASE + 2 * i)) begin
							rd_val = meas_sig_volt[i];
						end
						if (bus_addr == 5'(`CDSB_REF_BASE + 2 * i)) begin
							rd_val = meas_ref_volt[i];
						end
					end
				end
				`CDSB_PG_THR: begin
					for (int i = 0; i < NCH; i++) begin
						if (bus_addr == 5'(`CDSB_SIG_BASE + 2 * i)) begin
							rd_val = sig_thr[i];
						end
						if (bus_addr == 5'(`CDSB_REF_BASE + 2 * i)) begin
							rd_val = ref_thr[i];
						end
					end
				end
				default: ;
			endcase
		end
		for (int i = 0; i < NCH; i++) begin
			next_pos_out[i] = ctrl[`CDSB_WRAP_BIT] ? test_angle : meas_pos[i];
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_rdata <= '0;
			pos_out <= '0;
			input_isolate <= 1'b0;
			stim_enable <= 1'b0;
			bw_auto <= '0;
			enc_res <= {NCH{3'(`CDSB_RES_RST)}};
			comm_mode <= '0;
		end else begin
			if (bus_rd) begin
				bus_rdata <= rd_val;
			end
			pos_out <= next_pos_out;
			input_isolate <= next_ctrl[`CDSB_WRAP_BIT] | next_ctrl[`CDSB_OFFLINE_BIT];
			stim_enable <= next_off_state == OFF_RUN;
			bw_auto <= next_bw_sel;
			for (int i = 0; i < NCH; i++) begin
				enc_res[i] <= next_res[i][2:0];
				comm_mode[i] <= next_res[i][`CDSB_ENC_MODE_BIT];
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	AST_FREQ_READ: assert property (bus_rd && !page_hit && page == `CDSB_PG_FREQ && bus_addr == 5'h00
		|=> bus_rdata == $past(meas_freq[0])) else $error("frequency readback wrong");
	AST_VOLT_READ: assert property (bus_rd && !page_hit && page == `CDSB_PG_VOLT && bus_addr == 5'h02
		|=> bus_rdata == $past(meas_sig_volt[1])) else $error("signal voltage readback wrong");
	AST_WRAP_POS: assert property (ctrl[`CDSB_WRAP_BIT] |=> pos_out[3] == $past(test_angle))
		else $error("wrap position not test angle");
	AST_MON_OFF: assert property (!mon_on |-> (ref_evt == '0) && (sig_evt == '0) ##1 sig_cnt[0] == '0)
		else $error("loss monitor active during test");
	AST_OFF_DONE: assert property (off_state == OFF_RUN && off_step == 7'(`CDSB_OFF_ANGLES - 1)
		&& off_timer == OSW'(OFF_STEP_CYCLES - 1) && !wr_ctrl |=> !ctrl[`CDSB_OFFLINE_BIT] && off_state == OFF_IDLE)
		else $error("stimulus test did not clear enable");
	AST_ABORT: assert property (off_state == OFF_RUN && off_abort |=> off_state == OFF_IDLE && !stim_enable)
		else $error("stimulus test not aborted");
	AST_INACTIVE_ZERO: assert property (rd_acc |=> (bus_rdata[NCH-1:0] & ~$past(active)) == '0)
		else $error("inactive channel reports accuracy fault");
	AST_ACC_STICKY: assert property (acc_stat[0] && !rd_acc && !bus_wr |=> acc_stat[0])
		else $error("accuracy status dropped without read");
	AST_SET_WINS: assert property (rd_ref && ref_evt[1] && !bus_wr |=> ref_stat[1] && sum_stat[`CDSB_SUM_REF_BIT])
		else $error("reference event lost on clearing read");
	AST_SIG_DELAY: assert property ($rose(sig_evt[1]) |-> $past(sig_low[1] && active[1] && mon_on, 1))
		else $error("signal loss flagged without persistence");
	AST_SUM_LATCH: assert property (|acc_evt |=> sum_stat[`CDSB_SUM_ACC_BIT])
		else $error("summary missed accuracy event");
endmodule
